// [rss_pkg.sv]
// package: constants, types and carriers of the reset source sequencer
package rss_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h10;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int unsigned CMD_PROC_BIT = 0;
  localparam int unsigned CMD_EXT_BIT = 1;

  localparam int unsigned MODE_WDEN_BIT = 0;
  localparam int unsigned MODE_LEN_LSB = 8;
  localparam int unsigned LEN_W = 4;
  localparam logic MODE_WDEN_RST = 1'b1;
  localparam logic [LEN_W-1:0] MODE_LEN_RST = 4'h0;

  localparam int unsigned STAT_CAUSE_LSB = 0;
  localparam int unsigned CAUSE_W = 3;
  localparam int unsigned STAT_PIN_BIT = 8;
  localparam int unsigned STAT_BUSY_BIT = 16;

  // reset_cause_field codes
  localparam logic [CAUSE_W-1:0] CAUSE_POWERUP = 3'h0;
  localparam logic [CAUSE_W-1:0] CAUSE_BACKUP = 3'h1;
  localparam logic [CAUSE_W-1:0] CAUSE_WDOG = 3'h2;
  localparam logic [CAUSE_W-1:0] CAUSE_SOFT = 3'h3;
  localparam logic [CAUSE_W-1:0] CAUSE_USER = 3'h4;

  // interrupt events, same layout in status and mask
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_BACKUP = 0;
  localparam int unsigned EV_WDOG = 1;
  localparam int unsigned EV_SOFT = 2;
  localparam int unsigned EV_USER = 3;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;

  // ----------------------------------------------------------------
  // timing, in slow clock cycles
  // ----------------------------------------------------------------
  localparam int unsigned HOLD_W = 2;
  localparam int unsigned HOLD_CYC = 3;
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYC - 1);

  // pin low time is 2^(len+1) cycles
  localparam int unsigned EXT_CNT_W = 17;
  localparam logic [EXT_CNT_W:0] EXT_ONE = 18'h00001;
  localparam logic [LEN_W:0] LEN_INC = 5'h01;

  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned RISE_ALLOW = 1;
  localparam int unsigned GUARD_W = 2;
  localparam logic [GUARD_W-1:0] GUARD_LOAD = GUARD_W'(SYNC_STAGES + RISE_ALLOW);

  // ----------------------------------------------------------------
  // synchroniser lanes
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_W = 2;
  localparam int unsigned SYNC_BACKUP = 0;
  localparam int unsigned SYNC_PIN = 1;
  // pin idles high through its pull-up
  localparam logic [SYNC_W-1:0] SYNC_RST = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BACKUP,
    ST_WDOG,
    ST_SOFT,
    ST_USER
  } rss_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rss_bus_req_s;

  typedef struct packed {
    logic core_n;
    logic proc_n;
    logic periph_n;
    logic wdt_n;
  } rss_rst_s;

  localparam rss_rst_s RST_OUT_RST = '{core_n: 1'b1, proc_n: 1'b0, periph_n: 1'b0, wdt_n: 1'b0};

endpackage : rss_pkg

// [rss_sync.sv]
// two-stage synchroniser for the pin and supply inputs
module rss_sync (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [rss_pkg::SYNC_W-1:0] async_i,
  output logic [rss_pkg::SYNC_W-1:0] sync_o
);
  import rss_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] safe;
  } rss_sync_s;

  rss_sync_s st;
  rss_sync_s next_st;

  // first stage feeds only the second
  always_comb begin
    next_st = st;
    next_st.meta = async_i;
    next_st.safe = st.meta;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '{meta: SYNC_RST, safe: SYNC_RST};
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.safe;

endmodule : rss_sync

// [rss_sequencer.sv]
// reset source sequencer: backup, watchdog, software and user reset control
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.

// Summary of operation
// - on backup exit assert core supply reset, then record backup as cause
// - core supply reset stays asserted for the whole backup exit
// - watchdog fault enters watchdog reset, lasting exactly three slow cycles
// - processor and peripheral resets asserted throughout watchdog reset
// - watchdog reset drives pin low for set length; own low is not user reset
// - processor reset also resets the watchdog, restarting it at defaults
// - watchdog enable 0 ignores faults; 1 makes a fault in idle a processor reset
// - pin rising later than one cycle after watchdog reset releases it reports user reset
// - processor command bit resets processor and all peripherals
// - external command bit drives pin low for the programmed length
// - software reset on any command bit, alone or both together
// - software reset lasts exactly three slow cycles
module rss_sequencer (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire rss_pkg::rss_bus_req_s bus_i,
  output logic [rss_pkg::DATA_W-1:0] rdata_o,
  input wire logic backup_exit_i,
  input wire logic wd_fault_i,
  input wire logic ext_rst_pin_i,
  output logic ext_rst_pin_o,
  output logic ext_rst_pin_oe_n_o,
  output rss_pkg::rss_rst_s resets_o,
  output logic irq_o
);
  import rss_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rss_state_e state;
    logic [HOLD_W-1:0] hold;
    logic soft_proc;
    logic ext_drive;
    logic [EXT_CNT_W-1:0] ext_cnt;
    logic [GUARD_W-1:0] guard;
    logic wd_en;
    logic [LEN_W-1:0] ext_len;
    logic [CAUSE_W-1:0] cause;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic [DATA_W-1:0] rdata;
    rss_rst_s rst;
    logic irq;
  } rss_seq_s;

  localparam rss_seq_s SEQ_RST = '{
    state: ST_IDLE,
    hold: '0,
    soft_proc: 1'b0,
    ext_drive: 1'b0,
    ext_cnt: '0,
    guard: '0,
    wd_en: MODE_WDEN_RST,
    ext_len: MODE_LEN_RST,
    cause: CAUSE_POWERUP,
    irq_stat: '0,
    irq_mask: IRQ_MASK_RST,
    rdata: '0,
    rst: RST_OUT_RST,
    irq: 1'b0
  };

  rss_seq_s st;
  rss_seq_s next_st;

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic backup_s;
  logic pin_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic rss_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offset
  );
    rss_hit = (addr == offset);
  endfunction : rss_hit

  // pin low for 2^(len+1) cycles, counter runs load..0
  function automatic logic [EXT_CNT_W-1:0] rss_ext_load(
    input logic [LEN_W-1:0] len
  );
    logic [EXT_CNT_W:0] span;
    span = EXT_ONE << ({1'b0, len} + LEN_INC);
    rss_ext_load = EXT_CNT_W'(span - EXT_ONE);
  endfunction : rss_ext_load

  // processor side held low in these states
  function automatic logic rss_proc_held(
    input rss_state_e state,
    input logic soft_proc
  );
    case (state)
      ST_BACKUP, ST_WDOG, ST_USER: begin
        rss_proc_held = 1'b1;
      end
      ST_SOFT: begin
        rss_proc_held = soft_proc;
      end
      default: begin
        rss_proc_held = 1'b0;
      end
    endcase
  endfunction : rss_proc_held

  // read back; command word and unmapped offsets read zero
  function automatic logic [DATA_W-1:0] rss_read_word(
    input rss_seq_s s,
    input logic [ADDR_W-1:0] addr,
    input logic pin
  );
    logic [DATA_W-1:0] word;
    word = '0;
    case (addr)
      ADDR_MODE: begin
        word[MODE_WDEN_BIT] = s.wd_en;
        word[MODE_LEN_LSB +: LEN_W] = s.ext_len;
      end
      ADDR_STAT: begin
        word[STAT_CAUSE_LSB +: CAUSE_W] = s.cause;
        word[STAT_PIN_BIT] = pin;
        word[STAT_BUSY_BIT] = (s.state != ST_IDLE) || s.ext_drive;
      end
      ADDR_IRQ_STAT: begin
        word[EV_W-1:0] = s.irq_stat;
      end
      ADDR_IRQ_MASK: begin
        word[EV_W-1:0] = s.irq_mask;
      end
      default: begin
        word = '0;
      end
    endcase
    rss_read_word = word;
  endfunction : rss_read_word

  // ----------------------------------------------------------------
  // state update helpers
  // ----------------------------------------------------------------
  // entry into a counted reset state, cause recorded at entry
  function automatic rss_seq_s rss_enter(
    input rss_seq_s s,
    input rss_state_e state,
    input logic [CAUSE_W-1:0] cause
  );
    rss_enter = s;
    rss_enter.state = state;
    rss_enter.hold = HOLD_LOAD;
    rss_enter.cause = cause;
  endfunction : rss_enter

  // restart the pin pulse; guard reloads only when the drive ends
  function automatic rss_seq_s rss_pin_start(
    input rss_seq_s s,
    input logic [LEN_W-1:0] len
  );
    rss_pin_start = s;
    rss_pin_start.ext_drive = 1'b1;
    rss_pin_start.ext_cnt = rss_ext_load(len);
    rss_pin_start.guard = '0;
  endfunction : rss_pin_start

  // write one clears; an event in the same cycle wins
  function automatic logic [EV_W-1:0] rss_w1c(
    input logic [EV_W-1:0] stat,
    input logic clr_wr,
    input logic [EV_W-1:0] clr,
    input logic [EV_W-1:0] ev
  );
    logic [EV_W-1:0] kept;
    kept = clr_wr ? (stat & ~clr) : stat;
    rss_w1c = kept | ev;
  endfunction : rss_w1c

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  always_comb begin
    sync_in = '0;
    sync_in[SYNC_BACKUP] = backup_exit_i;
    sync_in[SYNC_PIN] = ext_rst_pin_i;
  end

  rss_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .async_i(sync_in),
    .sync_o(sync_out)
  );

  assign backup_s = sync_out[SYNC_BACKUP];
  assign pin_s = sync_out[SYNC_PIN];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic cmd_wr;
    logic cmd_proc;
    logic cmd_ext;
    logic pin_user;
    logic [EV_W-1:0] ev;
    logic mode_wr;
    logic mask_wr;
    logic stat_wr;
    cmd_wr = bus_i.wr && rss_hit(bus_i.addr, ADDR_CMD);
    mode_wr = bus_i.wr && rss_hit(bus_i.addr, ADDR_MODE);
    mask_wr = bus_i.wr && rss_hit(bus_i.addr, ADDR_IRQ_MASK);
    stat_wr = bus_i.wr && rss_hit(bus_i.addr, ADDR_IRQ_STAT);
    cmd_proc = cmd_wr && bus_i.wdata[CMD_PROC_BIT];
    cmd_ext = cmd_wr && bus_i.wdata[CMD_EXT_BIT];
    pin_user = 1'b0;
    ev = '0;
    next_st = st;
    next_st.rdata = '0;

    // ----------------------------------------------------------------
    // mode and mask writes
    // ----------------------------------------------------------------
    if (mode_wr) begin
      next_st.wd_en = bus_i.wdata[MODE_WDEN_BIT];
      next_st.ext_len = bus_i.wdata[MODE_LEN_LSB +: LEN_W];
    end
    if (mask_wr) begin
      next_st.irq_mask = bus_i.wdata[EV_W-1:0];
    end

    // ----------------------------------------------------------------
    // pin driver; guard masks our own low until the pin could rise
    // ----------------------------------------------------------------
    if (st.ext_drive) begin
      if (st.ext_cnt == '0) begin
        next_st.ext_drive = 1'b0;
        next_st.guard = GUARD_LOAD;
      end else begin
        next_st.ext_cnt = st.ext_cnt - 1'b1;
      end
    end else if (st.guard != '0) begin
      next_st.guard = st.guard - 1'b1;
    end

    // slow rc rise outlives the guard and lands as user reset
    pin_user = !pin_s && !st.ext_drive && (st.guard == '0);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    case (st.state)
      ST_IDLE: begin
        if (backup_s) begin
          next_st.state = ST_BACKUP;
        end else if (wd_fault_i && st.wd_en) begin
          next_st = rss_enter(next_st, ST_WDOG, CAUSE_WDOG);
          next_st = rss_pin_start(next_st, st.ext_len);
          ev[EV_WDOG] = 1'b1;
        end else if (cmd_proc || cmd_ext) begin
          next_st = rss_enter(next_st, ST_SOFT, CAUSE_SOFT);
          next_st.soft_proc = cmd_proc;
          if (cmd_ext) begin
            next_st = rss_pin_start(next_st, st.ext_len);
          end
          ev[EV_SOFT] = 1'b1;
        end else if (pin_user) begin
          next_st.state = ST_USER;
          next_st.cause = CAUSE_USER;
          ev[EV_USER] = 1'b1;
        end
      end
      ST_BACKUP: begin
        // cause recorded once the supply has let go
        if (!backup_s) begin
          next_st.state = ST_IDLE;
          next_st.cause = CAUSE_BACKUP;
          ev[EV_BACKUP] = 1'b1;
        end
      end
      ST_WDOG, ST_SOFT: begin
        if (st.hold == '0) begin
          next_st.state = ST_IDLE;
          next_st.soft_proc = 1'b0;
        end else begin
          next_st.hold = st.hold - 1'b1;
        end
      end
      ST_USER: begin
        if (pin_s) begin
          next_st.state = ST_IDLE;
        end
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // interrupt status
    // ----------------------------------------------------------------
    next_st.irq_stat = rss_w1c(st.irq_stat, stat_wr, bus_i.wdata[EV_W-1:0], ev);
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

    // ----------------------------------------------------------------
    // reset outputs follow the next state so they leave flops
    // ----------------------------------------------------------------
    next_st.rst.core_n = (next_st.state != ST_BACKUP);
    next_st.rst.proc_n = !rss_proc_held(next_st.state, next_st.soft_proc);
    next_st.rst.periph_n = next_st.rst.proc_n;
    next_st.rst.wdt_n = next_st.rst.proc_n;

    // ----------------------------------------------------------------
    // read data stands only in the cycle after the strobe
    // ----------------------------------------------------------------
    if (bus_i.rd) begin
      next_st.rdata = rss_read_word(st, bus_i.addr, pin_s);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= SEQ_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o = st.rdata;
  assign resets_o = st.rst;
  assign irq_o = st.irq;
  // open drain: only ever pulls low
  assign ext_rst_pin_o = 1'b0;
  assign ext_rst_pin_oe_n_o = !st.ext_drive;

endmodule : rss_sequencer

// [rss_asserts.sv]
// checker: port assertions of the reset source sequencer
module rss_asserts
  import rss_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire rss_pkg::rss_bus_req_s bus_i,
  input wire logic [rss_pkg::DATA_W-1:0] rdata_o,
  input wire logic backup_exit_i,
  input wire logic wd_fault_i,
  input wire logic ext_rst_pin_o,
  input wire logic ext_rst_pin_oe_n_o,
  input wire rss_pkg::rss_rst_s resets_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic cmd_wr;
  assign cmd_wr = bus_i.wr && bus_i.addr == ADDR_CMD;
  // ----------------------------------------------------------------
  // hold sequences and port checks
  // ----------------------------------------------------------------
  sequence seq_low3;
    !resets_o.proc_n [*3] ##1 resets_o.proc_n;
  endsequence
  chk_wdt_follows: assert property (resets_o.wdt_n == resets_o.proc_n)
    else $error("watchdog reset differs from processor reset");
  chk_periph_follows: assert property (resets_o.periph_n == resets_o.proc_n)
    else $error("peripheral reset differs from processor reset");
  chk_wdog_hold: assert property ($fell(resets_o.proc_n) && $past(wd_fault_i)
    && resets_o.core_n |-> seq_low3)
    else $error("watchdog reset not three cycles");
  chk_wdog_pin: assert property ($fell(resets_o.proc_n) && $past(wd_fault_i)
    && resets_o.core_n |-> !ext_rst_pin_oe_n_o && !ext_rst_pin_o)
    else $error("watchdog reset left the pin released");
  chk_soft_hold: assert property ($fell(resets_o.proc_n)
    && $past(cmd_wr && bus_i.wdata[0]) && resets_o.core_n |-> seq_low3)
    else $error("software reset not three cycles");
  chk_ext_only: assert property ($fell(ext_rst_pin_oe_n_o)
    && $past(cmd_wr && bus_i.wdata[1:0] == 2'h2) |-> resets_o.proc_n)
    else $error("pin command reset the processor");
  chk_zero_cmd: assert property (cmd_wr && bus_i.wdata[1:0] == 2'h0 && resets_o.proc_n
    && resets_o.core_n && ext_rst_pin_oe_n_o |=> ext_rst_pin_oe_n_o && resets_o.proc_n)
    else $error("empty command started a reset");
  chk_backup_core: assert property (backup_exit_i [*4] |->
    !resets_o.core_n && !resets_o.proc_n)
    else $error("core reset not held during backup exit");
  chk_pin_min: assert property ($fell(ext_rst_pin_oe_n_o) |=> !ext_rst_pin_oe_n_o)
    else $error("pin low shorter than two cycles");
  chk_pin_drain: assert property (!ext_rst_pin_oe_n_o |-> !ext_rst_pin_o)
    else $error("pin driven high");
  chk_read_stand: assert property (!$past(bus_i.rd) |-> rdata_o == '0)
    else $error("read data outside its cycle");
endmodule : rss_asserts

bind rss_sequencer rss_asserts rss_asserts_inst (.ref_clk_i, .resetn_i, .bus_i, .rdata_o,
  .backup_exit_i, .wd_fault_i, .ext_rst_pin_o, .ext_rst_pin_oe_n_o, .resets_o);

// [rss_partner.sv]
// partner: open-drain reset line with slow rise, and watchdog fault source
module rss_partner (
  input wire logic ref_clk_i,
  input wire logic pin_o_i,
  input wire logic pin_oe_n_i,
  input wire logic [3:0] rise_cyc_i,
  input wire logic kick_i,
  input wire logic wdt_n_i,
  output logic pin_level_o,
  output logic wd_fault_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] hold = 4'h0;
  always @(posedge ref_clk_i) begin
    // rc load keeps the line low a while after release
    if (!pin_oe_n_i) begin
      hold <= rise_cyc_i;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
    // a watchdog held in reset restarts and stays quiet
    wd_fault_o <= kick_i && wdt_n_i;
  end
  // pull-up level unless driven or still charging
  assign pin_level_o = !pin_oe_n_i ? pin_o_i : (hold == 4'h0);
endmodule : rss_partner

// [rss_sequencer_tb.sv]
// testbench: register, watchdog-fault and backup-exit scenarios for the reset sequencer
module rss_sequencer_tb;
  import rss_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  rss_bus_req_s bus_i = '0;
  logic backup_exit_i = 1'b0;
  logic kick = 1'b0;
  logic [3:0] rise = 4'h0;
  logic wd_fault, pin_level, pin_o, oe_n, irq_o;
  logic [DATA_W-1:0] rdata_o;
  rss_rst_s resets_o;
  int miscompares = 0;
  int tests_run = 0;
  int np, ne;
  always #10 ref_clk_i = ~ref_clk_i;
  rss_sequencer rss_sequencer_inst (.ref_clk_i, .resetn_i, .bus_i, .rdata_o, .backup_exit_i,
    .wd_fault_i(wd_fault), .ext_rst_pin_i(pin_level), .ext_rst_pin_o(pin_o),
    .ext_rst_pin_oe_n_o(oe_n), .resets_o, .irq_o);
  rss_partner rss_partner_inst (.ref_clk_i, .pin_o_i(pin_o), .pin_oe_n_i(oe_n),
    .rise_cyc_i(rise), .kick_i(kick), .wdt_n_i(resets_o.wdt_n), .pin_level_o(pin_level),
    .wd_fault_o(wd_fault));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    bus_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    bus_i.wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    bus_i <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    bus_i.rd <= 1'b0;
    @(negedge ref_clk_i);
    chk(rdata_o, exp);
  endtask : rd_chk
  // counts low cycles of the processor, peripheral and watchdog resets and of the pin drive
  task automatic measure;
    np = 0;
    ne = 0;
    repeat (24) begin
      @(negedge ref_clk_i);
      if (resets_o.proc_n === 1'b0 && resets_o.periph_n === 1'b0 && resets_o.wdt_n === 1'b0)
        np++;
      if (oe_n === 1'b0)
        ne++;
    end
  endtask : measure
  task automatic fault;
    @(posedge ref_clk_i);
    kick <= 1'b1;
    @(posedge ref_clk_i);
    kick <= 1'b0;
    @(posedge ref_clk_i);
    measure;
  endtask : fault
  task automatic complete_run;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    #50000;
    miscompares++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd_chk(ADDR_MODE, 32'h1);
    rd_chk(ADDR_STAT, 32'h100);
    rd_chk(ADDR_IRQ_MASK, 32'h0);
    rd_chk(8'h20, 32'h0);
    wr(ADDR_IRQ_MASK, 32'hf);
    fault;
    chk(np, 3);
    chk(ne, 2);
    rd_chk(ADDR_STAT, 32'h102);
    rd_chk(ADDR_IRQ_STAT, 32'h2);
    chk(irq_o, 1'b1);
    wr(ADDR_IRQ_STAT, 32'hf);
    rd_chk(ADDR_IRQ_STAT, 32'h0);
    chk(irq_o, 1'b0);
    wr(ADDR_MODE, 32'h100);
    fault;
    chk(np + ne, 0);
    wr(ADDR_MODE, 32'h101);
    wr(ADDR_IRQ_MASK, 32'h0);
    wr(ADDR_CMD, 32'h3);
    measure;
    chk(np, 3);
    chk(ne, 4);
    rd_chk(ADDR_STAT, 32'h103);
    rd_chk(ADDR_IRQ_STAT, 32'h4);
    chk(irq_o, 1'b0);
    wr(ADDR_CMD, 32'h2);
    measure;
    chk(np, 0);
    chk(ne, 4);
    wr(ADDR_CMD, 32'h0);
    measure;
    chk(np + ne, 0);
    rd_chk(ADDR_CMD, 32'h0);
    wr(ADDR_MODE, 32'h1);
    rise <= 4'h5;
    fault;
    rd_chk(ADDR_STAT, 32'h104);
    rise <= 4'h0;
    @(posedge ref_clk_i);
    backup_exit_i <= 1'b1;
    repeat (6) @(negedge ref_clk_i);
    chk(resets_o.core_n, 1'b0);
    @(posedge ref_clk_i);
    backup_exit_i <= 1'b0;
    measure;
    rd_chk(ADDR_STAT, 32'h101);
    complete_run;
  end
endmodule : rss_sequencer_tb
